/* File: hdl/pme_engine.sv */
// Purpose: Measurement sequencer, current and power arithmetic, result registers
// Assumes: Converter codes are on the core clock and stable when a period ends
// Notes: Register port addressed by register index, read data one cycle later
`timescale 1ns/1ns
module pme_engine #(
	parameter int unsigned CT_US [8] = pme_pkg::CT_US_DEFAULT
) (
	// Clock and reset
	input wire logic core_clk_i,
	input wire logic srst_i,
	// Register port
	input wire logic [pme_pkg::ADDR_W-1:0] reg_addr_i,
	input wire logic [pme_pkg::DATA_W-1:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	output logic [pme_pkg::DATA_W-1:0] reg_rdata_o,
	// Converter
	output logic conv_start_o,
	output logic conv_bus_sel_o,
	output logic mod_sample_o,
	input wire logic [15:0] shunt_code_i,
	input wire logic [15:0] bus_code_i,
	// Status
	output logic conversion_done_flag_o,
	output logic irq_o
);
	////////////////////////////////////////////////////////////////////////////////
	// Helpers
	typedef logic signed [pme_pkg::ACC_W-1:0] pme_acc_t;

	// Arithmetic shift that rounds toward zero
	function automatic pme_acc_t trunc_shift(input pme_acc_t v, input int unsigned sh);
		pme_acc_t bias;
		bias = v[pme_pkg::ACC_W-1] ? pme_acc_t'((64'h1 << sh) - 64'h1) : '0;
		return (v + bias) >>> sh;
	endfunction : trunc_shift

	function automatic logic [15:0] sat_s16(input pme_acc_t v);
		if (v > pme_acc_t'(16'sh7fff)) begin
			return 16'h7fff;
		end else if (v < -pme_acc_t'(17'sh08000)) begin
			return 16'h8000;
		end
		return v[15:0];
	endfunction : sat_s16

	function automatic logic [pme_pkg::TMR_W-1:0] ct_cycles(input logic [2:0] code);
		return pme_pkg::TMR_W'(CT_US[code] * pme_pkg::NS_PER_US / pme_pkg::CLK_PERIOD_NS);
	endfunction : ct_cycles

	////////////////////////////////////////////////////////////////////////////////
	// Declarations
	logic [15:0] setup_ff, nxt_setup;
	logic [15:0] scale_ff, nxt_scale;
	logic [pme_pkg::ST_W-1:0] status_ff, nxt_status, mask_ff, nxt_mask;
	logic [15:0] rdata_ff, nxt_rdata;
	logic irq_ff, nxt_irq;
	logic [15:0] shunt_res_ff, nxt_shunt_res, bus_res_ff, nxt_bus_res;
	logic [15:0] pwr_res_ff, nxt_pwr_res, cur_res_ff, nxt_cur_res;
	pme_pkg::pme_state_t state_ff;
	pme_pkg::pme_state_t nxt_state;
	logic [15:0] sh_smp_ff, nxt_sh_smp, cur_smp_ff, nxt_cur_smp;
	pme_acc_t acc_sh_ff, nxt_acc_sh, acc_bus_ff, nxt_acc_bus;
	pme_acc_t acc_cur_ff, nxt_acc_cur, acc_pwr_ff, nxt_acc_pwr;
	logic [pme_pkg::SCNT_W-1:0] scnt_ff, nxt_scnt;
	logic [4:0] mod_cnt_ff, nxt_mod_cnt;
	logic mod_ff, nxt_mod;
	logic cstart_ff, nxt_cstart, csel_ff, nxt_csel;
	logic [2:0] mode;
	logic [3:0] avg_sh;
	logic setup_wr, start_wr, stop_wr, done_evt, sat_evt;
	logic tmr_load, tmr_done, div_start, div_done;
	logic [pme_pkg::TMR_W-1:0] tmr_val;
	logic [31:0] div_dividend, div_quot;
	logic [15:0] bus_now, cur_src, cur_mag;
	pme_acc_t prod, cur_full;

	////////////////////////////////////////////////////////////////////////////////
	// Submodules
	pme_period_timer #(.CNT_W(pme_pkg::TMR_W)) u_timer (
		.core_clk_i(core_clk_i),
		.srst_i(srst_i),
		.load_i(tmr_load),
		.load_val_i(tmr_val),
		.done_o(tmr_done)
	);

	pme_serial_div #(.W(32), .DIVISOR(pme_pkg::POWER_DIVISOR)) u_div (
		.core_clk_i(core_clk_i),
		.srst_i(srst_i),
		.start_i(div_start),
		.dividend_i(div_dividend),
		.quot_o(div_quot),
		.done_o(div_done)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Register file
	assign mode = pme_pkg::fld3(setup_ff, pme_pkg::MODE_LSB);
	assign avg_sh = pme_pkg::AVG_LOG2[pme_pkg::fld3(setup_ff, pme_pkg::AVG_LSB)];
	assign setup_wr = reg_wr_i && (reg_addr_i == pme_pkg::REG_SETUP);
	assign start_wr = setup_wr && pme_pkg::mode_active(reg_wdata_i[2:0]);
	assign stop_wr = setup_wr && !pme_pkg::mode_active(reg_wdata_i[2:0]);

	always_comb begin
		nxt_setup = setup_wr ? reg_wdata_i : setup_ff;
		nxt_scale = (reg_wr_i && reg_addr_i == pme_pkg::REG_SCALE) ? reg_wdata_i : scale_ff;
		nxt_mask = (reg_wr_i && reg_addr_i == pme_pkg::REG_MASK) ?
			reg_wdata_i[pme_pkg::ST_W-1:0] : mask_ff;
		nxt_status = status_ff;
		if (reg_wr_i && reg_addr_i == pme_pkg::REG_STATUS) begin
			nxt_status = status_ff & ~reg_wdata_i[pme_pkg::ST_W-1:0];
		end
		if (start_wr) begin
			nxt_status[pme_pkg::ST_DONE] = 1'b0;
		end
		// Events applied last so a set in the clearing cycle is kept
		if (done_evt) begin
			nxt_status[pme_pkg::ST_DONE] = 1'b1;
		end
		if (sat_evt) begin
			nxt_status[pme_pkg::ST_SAT] = 1'b1;
		end
		nxt_irq = |(status_ff & mask_ff);
		nxt_rdata = 16'h0000;
		if (reg_rd_i) begin
			case (reg_addr_i)
				pme_pkg::REG_SETUP: nxt_rdata = setup_ff;
				pme_pkg::REG_SHUNT: nxt_rdata = shunt_res_ff;
				pme_pkg::REG_BUS: nxt_rdata = {1'b0, bus_res_ff[14:0]};
				pme_pkg::REG_POWER: nxt_rdata = (|scale_ff) ? pwr_res_ff : 16'h0000;
				pme_pkg::REG_CURRENT: nxt_rdata = (|scale_ff) ? cur_res_ff : 16'h0000;
				pme_pkg::REG_SCALE: nxt_rdata = scale_ff;
				pme_pkg::REG_STATUS: nxt_rdata = 16'(status_ff);
				pme_pkg::REG_MASK: nxt_rdata = 16'(mask_ff);
				default: nxt_rdata = 16'h0000;
			endcase
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (srst_i) begin
			setup_ff <= pme_pkg::SETUP_RESET;
			scale_ff <= 16'h0000;
			status_ff <= '0;
			mask_ff <= '0;
			rdata_ff <= 16'h0000;
			irq_ff <= 1'b0;
		end else begin
			setup_ff <= nxt_setup;
			scale_ff <= nxt_scale;
			status_ff <= nxt_status;
			mask_ff <= nxt_mask;
			rdata_ff <= nxt_rdata;
			irq_ff <= nxt_irq;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Arithmetic
	// Scale factor is unsigned, shunt reading signed
	assign prod = pme_acc_t'($signed(sh_smp_ff)) * pme_acc_t'({1'b0, scale_ff});
	assign cur_full = trunc_shift(prod, pme_pkg::CAL_DIV_SHIFT);
	assign bus_now = {1'b0, bus_code_i[14:0]}; // 1.25 mV per count, no scaling
	// Bus-only sets reuse the last stored current
	assign cur_src = mode[0] ? cur_smp_ff : cur_res_ff;
	assign cur_mag = cur_src[15] ? 16'(-$signed(cur_src)) : cur_src;
	// Dividing by 20000 fixes power weight at 25 current weights
	assign div_dividend = 32'(cur_mag) * 32'(bus_now);

	////////////////////////////////////////////////////////////////////////////////
	// Sequencer
	always_comb begin
		nxt_state = state_ff;
		nxt_sh_smp = sh_smp_ff;
		nxt_cur_smp = cur_smp_ff;
		nxt_acc_sh = acc_sh_ff;
		nxt_acc_bus = acc_bus_ff;
		nxt_acc_cur = acc_cur_ff;
		nxt_acc_pwr = acc_pwr_ff;
		nxt_scnt = scnt_ff;
		nxt_shunt_res = shunt_res_ff;
		nxt_bus_res = bus_res_ff;
		nxt_cur_res = cur_res_ff;
		nxt_pwr_res = pwr_res_ff;
		nxt_csel = csel_ff;
		tmr_load = 1'b0;
		div_start = 1'b0;
		done_evt = 1'b0;
		sat_evt = 1'b0;
		case (state_ff)
			pme_pkg::S_IDLE: begin
				// Triggered modes leave idle only on a fresh write
				if (start_wr || (mode[2] && pme_pkg::mode_active(mode))) begin
					nxt_state = pme_pkg::S_SAMPLE_END;
					nxt_scnt = '1;
					nxt_acc_sh = '0;
					nxt_acc_bus = '0;
					nxt_acc_cur = '0;
					nxt_acc_pwr = '0;
				end
			end
			pme_pkg::S_SH_CONV: begin
				if (tmr_done) begin
					nxt_sh_smp = shunt_code_i;
					nxt_state = pme_pkg::S_SH_MATH;
				end
			end
			pme_pkg::S_SH_MATH: begin
				nxt_cur_smp = (scale_ff == 16'h0000) ? 16'h0000 : sat_s16(cur_full);
				sat_evt = (scale_ff != 16'h0000) && (sat_s16(cur_full) != cur_full[15:0]);
				nxt_acc_sh = acc_sh_ff + pme_acc_t'($signed(sh_smp_ff));
				nxt_acc_cur = acc_cur_ff + pme_acc_t'($signed(nxt_cur_smp));
				nxt_state = pme_pkg::S_SAMPLE_END;
				if (mode[1]) begin
					tmr_load = 1'b1;
					nxt_csel = 1'b1;
					nxt_state = pme_pkg::S_BUS_CONV;
				end
			end
			pme_pkg::S_BUS_CONV: begin
				if (tmr_done) begin
					nxt_acc_bus = acc_bus_ff + pme_acc_t'(bus_now);
					div_start = 1'b1;
					nxt_state = pme_pkg::S_PWR_DIV;
				end
			end
			pme_pkg::S_PWR_DIV: begin
				if (div_done) begin
					nxt_acc_pwr = acc_pwr_ff + pme_acc_t'((scale_ff == 16'h0000) ? 32'h0 :
						((div_quot > 32'h0000ffff) ? 32'h0000ffff : div_quot));
					sat_evt = (div_quot > 32'h0000ffff);
					nxt_state = pme_pkg::S_SAMPLE_END;
				end
			end
			pme_pkg::S_SAMPLE_END: begin
				nxt_scnt = scnt_ff + 1'b1;
				if (scnt_ff == pme_pkg::SCNT_W'((32'h1 << avg_sh) - 32'h1)) begin
					nxt_state = pme_pkg::S_FINISH;
				end else begin
					tmr_load = 1'b1;
					nxt_csel = !mode[0];
					nxt_state = mode[0] ? pme_pkg::S_SH_CONV : pme_pkg::S_BUS_CONV;
				end
			end
			pme_pkg::S_FINISH: begin
				// Outputs change only here, after the final sample, or when a zero scale clears current and power
				if (mode[0]) begin
					nxt_shunt_res = 16'(trunc_shift(acc_sh_ff, avg_sh));
					nxt_cur_res = 16'(trunc_shift(acc_cur_ff, avg_sh));
				end
				if (mode[1]) begin
					nxt_bus_res = 16'(acc_bus_ff >>> avg_sh);
					nxt_pwr_res = 16'(acc_pwr_ff >>> avg_sh);
				end
				done_evt = 1'b1;
				nxt_state = pme_pkg::S_IDLE;
			end
			default: nxt_state = pme_pkg::S_IDLE;
		endcase
		if (scale_ff == 16'h0000) begin
			nxt_cur_res = 16'h0000;
			nxt_pwr_res = 16'h0000;
		end
		// New active write restarts the set, power-down aborts it
		if (stop_wr || start_wr) begin
			// A triggered write mid-set must still yield its one set
			nxt_state = stop_wr ? pme_pkg::S_IDLE : pme_pkg::S_SAMPLE_END;
			nxt_scnt = '1;
			nxt_acc_sh = '0;
			nxt_acc_bus = '0;
			nxt_acc_cur = '0;
			nxt_acc_pwr = '0;
			tmr_load = 1'b0;
			div_start = 1'b0;
			done_evt = 1'b0;
		end
		// Separate period fields per channel
		tmr_val = nxt_csel ? ct_cycles(pme_pkg::fld3(setup_ff, pme_pkg::BUSCT_LSB)) :
			ct_cycles(pme_pkg::fld3(setup_ff, pme_pkg::SHCT_LSB));
		nxt_cstart = tmr_load;
		// Modulator strobe runs only while converting
		nxt_mod = 1'b0;
		nxt_mod_cnt = 5'h00;
		if (state_ff == pme_pkg::S_SH_CONV || state_ff == pme_pkg::S_BUS_CONV) begin
			nxt_mod_cnt = mod_cnt_ff + 5'h01;
			if (mod_cnt_ff == 5'(pme_pkg::MOD_DIV_CYC - 1)) begin
				nxt_mod_cnt = 5'h00;
				nxt_mod = 1'b1;
			end
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (srst_i) begin
			state_ff <= pme_pkg::S_IDLE;
			sh_smp_ff <= 16'h0000;
			cur_smp_ff <= 16'h0000;
			acc_sh_ff <= '0;
			acc_bus_ff <= '0;
			acc_cur_ff <= '0;
			acc_pwr_ff <= '0;
			scnt_ff <= '0;
			shunt_res_ff <= 16'h0000;
			bus_res_ff <= 16'h0000;
			cur_res_ff <= 16'h0000;
			pwr_res_ff <= 16'h0000;
			cstart_ff <= 1'b0;
			csel_ff <= 1'b0;
			mod_cnt_ff <= 5'h00;
			mod_ff <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			sh_smp_ff <= nxt_sh_smp;
			cur_smp_ff <= nxt_cur_smp;
			acc_sh_ff <= nxt_acc_sh;
			acc_bus_ff <= nxt_acc_bus;
			acc_cur_ff <= nxt_acc_cur;
			acc_pwr_ff <= nxt_acc_pwr;
			scnt_ff <= nxt_scnt;
			shunt_res_ff <= nxt_shunt_res;
			bus_res_ff <= nxt_bus_res;
			cur_res_ff <= nxt_cur_res;
			pwr_res_ff <= nxt_pwr_res;
			cstart_ff <= nxt_cstart;
			csel_ff <= nxt_csel;
			mod_cnt_ff <= nxt_mod_cnt;
			mod_ff <= nxt_mod;
		end
	end

	assign reg_rdata_o = rdata_ff;
	assign conv_start_o = cstart_ff;
	assign conv_bus_sel_o = csel_ff;
	assign mod_sample_o = mod_ff;
	assign conversion_done_flag_o = status_ff[pme_pkg::ST_DONE];
	assign irq_o = irq_ff;
endmodule : pme_engine

/* File: hdl/pme_period_timer.sv */
// Purpose: Down counter that marks the end of one conversion period
// Assumes: Load value of at least one cycle
// Notes: Done is a one-cycle pulse, a new load restarts the count
`timescale 1ns/1ns
module pme_period_timer #(
	parameter int unsigned CNT_W = pme_pkg::TMR_W
) (
	// Clock and reset
	input wire logic core_clk_i,
	input wire logic srst_i,
	// Control
	input wire logic load_i,
	input wire logic [CNT_W-1:0] load_val_i,
	output logic done_o
);
	logic [CNT_W-1:0] cnt_ff;
	logic [CNT_W-1:0] nxt_cnt;
	logic done_ff;
	logic nxt_done;

	always_comb begin
		nxt_cnt = cnt_ff;
		nxt_done = 1'b0;
		if (load_i) begin
			nxt_cnt = load_val_i;
		end else if (cnt_ff != '0) begin
			nxt_cnt = cnt_ff - 1'b1;
			nxt_done = (cnt_ff == CNT_W'(1));
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (srst_i) begin
			cnt_ff <= '0;
			done_ff <= 1'b0;
		end else begin
			cnt_ff <= nxt_cnt;
			done_ff <= nxt_done;
		end
	end

	assign done_o = done_ff;
endmodule : pme_period_timer

/* File: hdl/pme_pkg.sv */
// Purpose: Shared constants, types and decoders of the power measurement engine
// Assumes: 10 MHz core clock, register port addressed by register index
// Notes: Conversion periods are counted on the core clock
package pme_pkg;
	////////////////////////////////////////////////////////////////////////////////
	localparam int unsigned CLK_PERIOD_NS = 100;
	localparam int unsigned NS_PER_US = 1000;
	localparam int unsigned ADC_RATE_HZ = 500000;
	localparam int unsigned NS_PER_S = 1000000000;
	localparam int unsigned MOD_DIV_CYC = NS_PER_S / (CLK_PERIOD_NS * ADC_RATE_HZ);
	localparam int unsigned CT_US_DEFAULT [8] = '{140, 204, 332, 588, 1100, 2116, 4156, 8244};
	localparam int unsigned TMR_W = 20;
	localparam logic [3:0] AVG_LOG2 [8] = '{4'h0, 4'h2, 4'h4, 4'h6, 4'h7, 4'h8, 4'h9, 4'ha};
	localparam int unsigned SCNT_W = 11;
	////////////////////////////////////////////////////////////////////////////////
	localparam int unsigned ADDR_W = 3;
	localparam int unsigned DATA_W = 16;
	localparam logic [2:0] REG_SETUP = 3'h0;
	localparam logic [2:0] REG_SHUNT = 3'h1;
	localparam logic [2:0] REG_BUS = 3'h2;
	localparam logic [2:0] REG_POWER = 3'h3;
	localparam logic [2:0] REG_CURRENT = 3'h4;
	localparam logic [2:0] REG_SCALE = 3'h5;
	localparam logic [2:0] REG_STATUS = 3'h6;
	localparam logic [2:0] REG_MASK = 3'h7;
	localparam logic [15:0] SETUP_RESET = 16'h4127;
	localparam int unsigned MODE_LSB = 0;
	localparam int unsigned SHCT_LSB = 3;
	localparam int unsigned BUSCT_LSB = 6;
	localparam int unsigned AVG_LSB = 9;
	localparam int unsigned ST_W = 2;
	localparam int unsigned ST_DONE = 0;
	localparam int unsigned ST_SAT = 1;
	////////////////////////////////////////////////////////////////////////////////
	localparam int unsigned CAL_DIV_SHIFT = 11;
	localparam logic [31:0] POWER_DIVISOR = 32'h00004e20;
	localparam int unsigned POWER_LSB_RATIO = 25;
	localparam int unsigned ACC_W = 40;

	typedef enum logic [2:0] {
		S_IDLE = 3'b000,
		S_SH_CONV = 3'b001,
		S_SH_MATH = 3'b010,
		S_BUS_CONV = 3'b011,
		S_PWR_DIV = 3'b100,
		S_SAMPLE_END = 3'b101,
		S_FINISH = 3'b110
	} pme_state_t;

	function automatic logic mode_active(input logic [2:0] mode);
		return (mode[1:0] != 2'h0);
	endfunction : mode_active

	function automatic logic [2:0] fld3(input logic [15:0] word, input int unsigned lsb);
		return word[lsb +: 3];
	endfunction : fld3
endpackage : pme_pkg

/* File: hdl/pme_serial_div.sv */
// Purpose: Restoring divider, one quotient bit per clock
// Assumes: Divisor is a nonzero constant
// Notes: Takes W cycles; a constant divider in one cycle would cost far more area
`timescale 1ns/1ns
module pme_serial_div #(
	parameter int unsigned W = 32,
	parameter logic [W-1:0] DIVISOR = pme_pkg::POWER_DIVISOR
) (
	// Clock and reset
	input wire logic core_clk_i,
	input wire logic srst_i,
	// Operands
	input wire logic start_i,
	input wire logic [W-1:0] dividend_i,
	output logic [W-1:0] quot_o,
	output logic done_o
);
	logic [W-1:0] quot_ff, nxt_quot;
	logic [W:0] rem_ff, nxt_rem;
	logic [5:0] cnt_ff, nxt_cnt;
	logic busy_ff, nxt_busy;
	logic done_ff, nxt_done;
	logic [W:0] trial;

	always_comb begin
		trial = '0;
		nxt_quot = quot_ff;
		nxt_rem = rem_ff;
		nxt_cnt = cnt_ff;
		nxt_busy = busy_ff;
		nxt_done = 1'b0;
		if (start_i) begin
			nxt_quot = dividend_i;
			nxt_rem = '0;
			nxt_cnt = 6'(W);
			nxt_busy = 1'b1;
		end else if (busy_ff) begin
			// Remainder dropped: quotient truncates
			trial = {rem_ff[W-1:0], quot_ff[W-1]};
			nxt_quot = {quot_ff[W-2:0], 1'b0};
			if (trial >= {1'b0, DIVISOR}) begin
				trial = trial - {1'b0, DIVISOR};
				nxt_quot[0] = 1'b1;
			end
			nxt_rem = trial;
			nxt_cnt = cnt_ff - 6'h01;
			if (cnt_ff == 6'h01) begin
				nxt_busy = 1'b0;
				nxt_done = 1'b1;
			end
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (srst_i) begin
			quot_ff <= '0;
			rem_ff <= '0;
			cnt_ff <= 6'h00;
			busy_ff <= 1'b0;
			done_ff <= 1'b0;
		end else begin
			quot_ff <= nxt_quot;
			rem_ff <= nxt_rem;
			cnt_ff <= nxt_cnt;
			busy_ff <= nxt_busy;
			done_ff <= nxt_done;
		end
	end

	assign quot_o = quot_ff;
	assign done_o = done_ff;
endmodule : pme_serial_div

/* File: tb/pme_conv_model.sv */
// Purpose: Behavioural converter feeding shunt and bus codes
// Assumes: Channel select is valid in the start cycle
// Notes: The channel not being converted scrambles every cycle
`timescale 1ns/1ns
module pme_conv_model (
	// Engine side
	input wire logic core_clk_i,
	input wire logic conv_start_i,
	input wire logic conv_bus_sel_i,
	// Values to present
	input wire logic [15:0] shunt_val_i,
	input wire logic [15:0] bus_val_i,
	output logic [15:0] shunt_code_o,
	output logic [15:0] bus_code_o
);
	logic [15:0] sh_ff = 16'h5a5a;
	logic [15:0] bus_ff = 16'ha5a5;
	logic [15:0] nxt_sh, nxt_bus;
	// Scrambling makes a latch at the wrong moment give a visibly wrong result
	always_comb begin
		nxt_sh = conv_bus_sel_i ? ~sh_ff : sh_ff;
		nxt_bus = conv_bus_sel_i ? bus_ff : ~bus_ff;
		if (conv_start_i && !conv_bus_sel_i) nxt_sh = shunt_val_i;
		if (conv_start_i && conv_bus_sel_i) nxt_bus = bus_val_i;
	end
	always_ff @(posedge core_clk_i) begin
		sh_ff <= nxt_sh;
		bus_ff <= nxt_bus;
	end
	assign shunt_code_o = sh_ff;
	assign bus_code_o = bus_ff;
endmodule : pme_conv_model

/* File: tb/pme_engine_monitor.sv */
// Purpose: Port checker for the measurement engine
// Assumes: Shadow registers land at the same edge as the engine's own
// Notes: Only engine ports are visible, so status is inferred from the flag
`timescale 1ns/1ns
module pme_engine_monitor #(
	parameter int unsigned CT_US [8] = pme_pkg::CT_US_DEFAULT
) (
	// Clock, reset and register port
	input wire logic core_clk_i,
	input wire logic srst_i,
	input wire logic [pme_pkg::ADDR_W-1:0] reg_addr_i,
	input wire logic [pme_pkg::DATA_W-1:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	input wire logic [pme_pkg::DATA_W-1:0] reg_rdata_o,
	// Converter and status
	input wire logic conv_start_o,
	input wire logic conv_bus_sel_o,
	input wire logic mod_sample_o,
	input wire logic [15:0] shunt_code_i,
	input wire logic [15:0] bus_code_i,
	input wire logic conversion_done_flag_o,
	input wire logic irq_o
);
	////////////////////////////////////////////////////////////////////////////////
	logic [15:0] setup_ff, scale_ff, mask_ff, gap_ff;
	logic [15:0] nxt_setup, nxt_scale, nxt_mask, nxt_gap;
	logic flag_ff, run_ff, trig_ff, nxt_run, nxt_trig, wr_setup;
	always_comb begin
		wr_setup = reg_wr_i && reg_addr_i == pme_pkg::REG_SETUP;
		nxt_setup = wr_setup ? reg_wdata_i : setup_ff;
		nxt_scale = (reg_wr_i && reg_addr_i == pme_pkg::REG_SCALE) ? reg_wdata_i : scale_ff;
		nxt_mask = (reg_wr_i && reg_addr_i == pme_pkg::REG_MASK) ? reg_wdata_i : mask_ff;
		// A set aborted by a write may still finish; arm only once the new set started
		nxt_run = !wr_setup && (run_ff || conv_start_o);
		nxt_trig = !wr_setup && (trig_ff || (conversion_done_flag_o && !flag_ff && run_ff
			&& !setup_ff[2]));
		nxt_gap = wr_setup ? 16'hffff : conv_start_o ? 16'h0 : gap_ff + {15'h0, gap_ff != 16'hffff};
	end
	always_ff @(posedge core_clk_i) begin
		if (srst_i) begin
			setup_ff <= pme_pkg::SETUP_RESET;
			scale_ff <= 16'h0;
			mask_ff <= 16'h0;
			gap_ff <= 16'hffff;
			flag_ff <= 1'b0;
			run_ff <= 1'b0;
			trig_ff <= 1'b0;
		end else begin
			setup_ff <= nxt_setup;
			scale_ff <= nxt_scale;
			mask_ff <= nxt_mask;
			gap_ff <= nxt_gap;
			flag_ff <= conversion_done_flag_o;
			run_ff <= nxt_run;
			trig_ff <= nxt_trig;
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (srst_i);
	rd_idle_a: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 16'h0)
		else $error("read data not idle");
	bus_msb_a: assert property ($past(reg_rd_i && reg_addr_i == pme_pkg::REG_BUS)
		|-> !reg_rdata_o[15]) else $error("bus reading top bit set");
	zero_scale_a: assert property ($past(reg_rd_i && scale_ff == 16'h0
		&& (reg_addr_i == pme_pkg::REG_POWER || reg_addr_i == pme_pkg::REG_CURRENT))
		|-> reg_rdata_o == 16'h0) else $error("result not zero without scale");
	setup_rb_a: assert property ($past(reg_rd_i && reg_addr_i == pme_pkg::REG_SETUP)
		|-> reg_rdata_o == $past(setup_ff)) else $error("setup readback wrong");
	start_pulse_a: assert property (conv_start_o |=> !conv_start_o)
		else $error("start longer than one cycle");
	trig_once_a: assert property (trig_ff |-> !conv_start_o)
		else $error("extra set without a write");
	period_min_a: assert property (conv_start_o && gap_ff != 16'hffff
		|-> gap_ff >= CT_US[0] * 10) else $error("conversion period too short");
	sel_hold_a: assert property (disable iff (srst_i || reg_wr_i)
		conv_start_o |=> $stable(conv_bus_sel_o) [*8]) else $error("channel changed early");
	sample_gap_a: assert property (mod_sample_o |=> !mod_sample_o [*8] ##1
		!mod_sample_o [*8]) else $error("sample strobe too fast");
	done_quiet_a: assert property ($rose(conversion_done_flag_o)
		|-> !conv_start_o && !mod_sample_o) else $error("done while converting");
	irq_on_a: assert property (mask_ff[0] && conversion_done_flag_o |=> irq_o)
		else $error("interrupt missing");
	irq_off_a: assert property (mask_ff == 16'h0 |=> !irq_o)
		else $error("interrupt while masked");
	cover property (conv_start_o && conv_bus_sel_o);
	cover property (irq_o);
	cover property (trig_ff && conversion_done_flag_o);
endmodule : pme_engine_monitor

bind pme_engine pme_engine_monitor #(.CT_US(CT_US)) i_pme_engine_monitor (
	.core_clk_i(core_clk_i), .srst_i(srst_i), .reg_addr_i(reg_addr_i),
	.reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
	.reg_rdata_o(reg_rdata_o), .conv_start_o(conv_start_o), .conv_bus_sel_o(conv_bus_sel_o),
	.mod_sample_o(mod_sample_o), .shunt_code_i(shunt_code_i), .bus_code_i(bus_code_i),
	.conversion_done_flag_o(conversion_done_flag_o), .irq_o(irq_o));

/* File: tb/power_measurement_engine_tb_top.sv */
// Purpose: Self-checking bench for the measurement engine
// Assumes: Short period table, 10 to 80 cycles per conversion
// Notes: Reads queue their expectation; a watcher compares the data
`timescale 1ns/1ns
module power_measurement_engine_tb_top;
	localparam int unsigned CT [8] = '{1, 2, 3, 4, 5, 6, 7, 8};
	logic core_clk_i = 1'b0;
	logic srst_i = 1'b1;
	logic wr = 1'b0, rd = 1'b0, rd_q = 1'b0, start, sel, msamp, flag, irq;
	logic [2:0] addr = 3'h0;
	logic [15:0] wdata = 16'h0, sh_val = 16'h0, bus_val = 16'h0, rdata, sh_code, bus_code;
	logic [15:0] e_sh, e_bus, e_cur, e_pwr, scale;
	logic [15:0] exp_q [$];
	int fail_count = 0, check_count = 0, starts = 0;
	pme_engine #(.CT_US(CT)) i_pme_engine (.core_clk_i(core_clk_i), .srst_i(srst_i),
		.reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd),
		.reg_rdata_o(rdata), .conv_start_o(start), .conv_bus_sel_o(sel), .mod_sample_o(msamp),
		.shunt_code_i(sh_code), .bus_code_i(bus_code), .conversion_done_flag_o(flag),
		.irq_o(irq));
	pme_conv_model i_pme_conv_model (.core_clk_i(core_clk_i), .conv_start_i(start),
		.conv_bus_sel_i(sel), .shunt_val_i(sh_val), .bus_val_i(bus_val),
		.shunt_code_o(sh_code), .bus_code_o(bus_code));
	initial begin
		forever #50 core_clk_i = ~core_clk_i;
	end
	////////////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		check_count++;
		if (seen !== exp) begin
			fail_count++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic test_done();
		$display("checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : test_done
	task automatic acc(input logic w, input logic [2:0] a, input logic [15:0] d);
		@(posedge core_clk_i);
		wr <= w;
		rd <= !w;
		addr <= a;
		wdata <= d;
		if (!w) exp_q.push_back(d);
	endtask : acc
	task automatic idle(input int n);
		@(posedge core_clk_i);
		wr <= 1'b0;
		rd <= 1'b0;
		repeat (n) @(posedge core_clk_i);
	endtask : idle
	task automatic wait_flag(input logic v);
		int n;
		n = 0;
		while (flag !== v && n < 20000) begin
			@(posedge core_clk_i);
			n++;
		end
		if (n == 20000) begin
			fail_count++;
			$display("[FAIL] %0t done flag wait ran out", $time);
			test_done();
		end
	endtask : wait_flag
	// Full-range values saturate often, which the trimmed reference must match
	function automatic logic [15:0] cur_f(input logic [15:0] sh, input logic [15:0] sc);
		longint p;
		p = longint'($signed(sh)) * longint'(sc) / 2048;
		if (p > 32767) p = 32767;
		if (p < -32768) p = -32768;
		return 16'(p);
	endfunction : cur_f
	function automatic logic [15:0] pwr_f(input logic [15:0] c, input logic [15:0] b);
		longint p;
		p = longint'($signed(c));
		if (p < 0) p = -p;
		p = p * longint'(b & 16'h7fff) / 20000;
		return (p > 65535) ? 16'hffff : 16'(p);
	endfunction : pwr_f
	task automatic run(input logic [2:0] mode, input logic [2:0] avg);
		if (mode[0]) e_sh = sh_val;
		if (mode[0]) e_cur = cur_f(sh_val, scale);
		if (mode[1]) e_bus = bus_val & 16'h7fff;
		if (mode[1]) e_pwr = pwr_f(e_cur, bus_val);
		starts = 0;
		acc(1'b1, pme_pkg::REG_SETUP, {4'h0, avg, 3'($urandom), 3'($urandom), mode});
		idle(0);
		wait_flag(1'b0);
		wait_flag(1'b1);
		chk(16'(starts), (16'(mode[0]) + 16'(mode[1])) << pme_pkg::AVG_LOG2[avg]);
		acc(1'b0, pme_pkg::REG_SHUNT, e_sh);
		acc(1'b0, pme_pkg::REG_BUS, e_bus);
		acc(1'b0, pme_pkg::REG_POWER, e_pwr);
		acc(1'b0, pme_pkg::REG_CURRENT, e_cur);
		idle(2);
	endtask : run
	always @(posedge core_clk_i) begin
		if (start) starts++;
		if (rd_q) chk(rdata, exp_q.pop_front());
		rd_q <= rd;
	end
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (8) @(posedge core_clk_i);
		srst_i <= 1'b0;
		void'($urandom(32'h730a));
		acc(1'b0, pme_pkg::REG_SETUP, pme_pkg::SETUP_RESET);
		acc(1'b0, pme_pkg::REG_SCALE, 16'h0);
		acc(1'b0, pme_pkg::REG_MASK, 16'h0);
		acc(1'b1, pme_pkg::REG_CURRENT, 16'hffff);
		acc(1'b0, pme_pkg::REG_CURRENT, 16'h0);
		acc(1'b0, pme_pkg::REG_POWER, 16'h0);
		acc(1'b1, pme_pkg::REG_SETUP, 16'h4120);
		idle(4);
		starts = 0;
		idle(200);
		chk(16'(starts), 16'h0);
		$display("test reset and power-down done");
		scale = 16'h0a00;
		sh_val = 16'h1f40;
		bus_val = 16'ha570;
		acc(1'b1, pme_pkg::REG_SCALE, scale);
		acc(1'b1, pme_pkg::REG_MASK, 16'h0001);
		run(3'h3, 3'h0);
		chk({15'h0, irq}, 16'h1);
		acc(1'b1, pme_pkg::REG_STATUS, 16'h0003);
		acc(1'b0, pme_pkg::REG_STATUS, 16'h0);
		acc(1'b0, pme_pkg::REG_MASK, 16'h0001);
		idle(2);
		chk({15'h0, irq}, 16'h0);
		$display("test worked example and interrupt done");
		scale = 16'($urandom) & 16'h7fff | 16'h0001;
		acc(1'b1, pme_pkg::REG_SCALE, scale);
		for (int i = 0; i < 9; i++) begin
			sh_val = 16'($urandom);
			bus_val = 16'($urandom);
			run(3'(i % 3 + 1), 3'h0);
		end
		$display("test triggered modes done");
		sh_val = 16'hff38;
		bus_val = 16'h9234;
		run(3'h3, 3'h1);
		$display("test averaging done");
		scale = 16'h0;
		acc(1'b1, pme_pkg::REG_SCALE, scale);
		acc(1'b0, pme_pkg::REG_CURRENT, 16'h0);
		acc(1'b0, pme_pkg::REG_POWER, 16'h0);
		run(3'h3, 3'h0);
		$display("test zero scale done");
		test_done();
	end
endmodule : power_measurement_engine_tb_top
